// >>> acr_regs.vh
`ifndef ACR_REGS_VH
`define ACR_REGS_VH
// register offsets
`define ACR_OFF_INPUT_SELECT 3'h0
`define ACR_OFF_CONTROL_A 3'h1
`define ACR_OFF_CONTROL_B 3'h2
`define ACR_OFF_RESULT_LOW 3'h3
`define ACR_OFF_RESULT_HIGH 3'h4
`define ACR_OFF_CORE_STATUS 3'h5
// reset values
`define ACR_RST_INPUT_SELECT 8'h00
`define ACR_RST_CONTROL_A 8'h00
`define ACR_RST_CONTROL_B 8'h00
// input select fields
`define ACR_REFSEL_HI 7
`define ACR_REFSEL_LO 6
`define ACR_LEFT_ADJ 5
`define ACR_MUX_HI 3
`define ACR_MUX_LO 0
// control a fields
`define ACR_EN 7
`define ACR_START 6
`define ACR_ATE 5
`define ACR_DONE 4
`define ACR_IRQEN 3
`define ACR_PS_HI 2
`define ACR_PS_LO 0
// control b fields
`define ACR_HSM 7
`define ACR_NCDIS 6
`define ACR_SSEN 4
`define ACR_TS_HI 3
`define ACR_TS_LO 0
// writable masks
`define ACR_MASK_INPUT_SELECT 8'hef
`define ACR_MASK_CONTROL_B 8'hdf
// reference codes
`define ACR_REF_EXT 2'h0
`define ACR_REF_AVCC 2'h1
`define ACR_REF_INT_CAP 2'h2
`define ACR_REF_INT_FREE 2'h3
// trigger source codes
`define ACR_TS_FREE 4'h0
`define ACR_TS_CMP1 4'h1
`define ACR_TS_EXT0 4'h2
`define ACR_TS_T1OVF 4'h3
`define ACR_TS_T1CAP 4'h4
`define ACR_TS_SYNC_R 4'h5
`define ACR_TS_SYNC_2 4'h6
`define ACR_TS_CMP2 4'h7
`define ACR_TS_CMP3 4'h8
// conversion timing in converter clocks
`define ACR_CONV_CYCLES 5'd13
`define ACR_INIT_CYCLES 5'd25
// prescaler terminal counts, divisor minus one
`define ACR_LIM_DIV2 7'h01
`define ACR_LIM_DIV4 7'h03
`define ACR_LIM_DIV8 7'h07
`define ACR_LIM_DIV16 7'h0f
`define ACR_LIM_DIV32 7'h1f
`define ACR_LIM_DIV64 7'h3f
`define ACR_LIM_DIV128 7'h7f
`endif

// >>> acr_prescaler.v
`timescale 1ns/1ps
`include "acr_regs.vh"
module acr_prescaler (
	// clock and reset
	input wire clk,
	input wire resetn,
	// control
	input wire run,
	input wire [2:0] sel,
	// converter clock enable
	output wire tick
);
	reg [6:0] cnt_reg;
	reg [6:0] lim;
	always @* begin
		case (sel)
			3'h0, 3'h1: lim = `ACR_LIM_DIV2;
			3'h2: lim = `ACR_LIM_DIV4;
			3'h3: lim = `ACR_LIM_DIV8;
			3'h4: lim = `ACR_LIM_DIV16;
			3'h5: lim = `ACR_LIM_DIV32;
			3'h6: lim = `ACR_LIM_DIV64;
			default: lim = `ACR_LIM_DIV128;
		endcase
	end
	// counter held at zero while idle, so the first tick phase is fixed
	always @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			cnt_reg <= 7'h00;
		end else if (!run || cnt_reg >= lim) begin
			cnt_reg <= 7'h00;
		end else begin
			cnt_reg <= cnt_reg + 7'h01;
		end
	end
	assign tick = run && (cnt_reg >= lim);
endmodule // acr_prescaler

// >>> acr_control.v
`timescale 1ns/1ps
`include "acr_regs.vh"
module acr_control (
	// clock and reset
	input wire CORE_CLK,
	input wire RESETN,
	// register port
	input wire [2:0] REG_ADDR,
	input wire [7:0] REG_WDATA,
	input wire REG_WR,
	input wire REG_RD,
	output reg [7:0] REG_RDATA,
	// interrupt vector
	input wire IRQ_ACK,
	output wire IRQ_REQ,
	// sleep entry
	input wire SLEEP_ENTRY,
	// trigger sources, asynchronous to the core
	input wire CMP1_FLAG,
	input wire EXT0_FLAG,
	input wire T1_OVF_FLAG,
	input wire T1_CAP_FLAG,
	input wire STAGE_R_SYNC_EVENT,
	input wire STAGE_2_SYNC_EVENT,
	input wire CMP2_FLAG,
	input wire CMP3_FLAG,
	// analog core
	input wire [9:0] CORE_RESULT,
	output reg [1:0] REF_SEL,
	output reg [3:0] INPUT_SEL,
	output wire INT_REF_ON,
	output wire HIGH_SPEED,
	output wire CORE_ENABLE,
	output reg SAMPLE,
	output wire CONV_CLK_EN,
	output reg INIT_CYCLE
);
	localparam ST_IDLE = 3'b001;
	localparam ST_CONV = 3'b010;
	localparam ST_DONE = 3'b100;

	reg [7:0] in_sel_reg;
	reg [7:0] ctl_a_reg;
	reg [7:0] ctl_b_reg;
	reg [2:0] state_reg;
	reg [4:0] cnt_reg;
	reg [9:0] result_reg;
	reg lock_reg;
	reg ss_block_reg;
	reg need_init_reg;
	reg pend_mux_reg;
	reg [7:0] pend_val_reg;
	reg [7:0] trig_s1_reg;
	reg [7:0] trig_s2_reg;
	reg [7:0] trig_d_reg;
	reg sleep_d_reg;

	wire wr_in = REG_WR && REG_ADDR == `ACR_OFF_INPUT_SELECT;
	wire wr_a = REG_WR && REG_ADDR == `ACR_OFF_CONTROL_A;
	wire wr_b = REG_WR && REG_ADDR == `ACR_OFF_CONTROL_B;
	wire rd_lo = REG_RD && REG_ADDR == `ACR_OFF_RESULT_LOW;
	wire rd_hi = REG_RD && REG_ADDR == `ACR_OFF_RESULT_HIGH;
	wire busy = state_reg == ST_CONV;
	wire en = ctl_a_reg[`ACR_EN];
	wire [3:0] ts = ctl_b_reg[`ACR_TS_HI:`ACR_TS_LO];
	wire tick;

	// two-flop synchroniser; only the second stage feeds edge logic
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			trig_s1_reg <= 8'h00;
			trig_s2_reg <= 8'h00;
			trig_d_reg <= 8'h00;
			sleep_d_reg <= 1'b0;
		end else begin
			trig_s1_reg <= {CMP3_FLAG, CMP2_FLAG, STAGE_2_SYNC_EVENT, STAGE_R_SYNC_EVENT,
				T1_CAP_FLAG, T1_OVF_FLAG, EXT0_FLAG, CMP1_FLAG};
			trig_s2_reg <= trig_s1_reg;
			trig_d_reg <= trig_s2_reg;
			sleep_d_reg <= SLEEP_ENTRY;
		end
	end
	wire [7:0] rise = trig_s2_reg & ~trig_d_reg;

	reg trig_hit;
	always @* begin
		trig_hit = 1'b0;
		case (ts)
			`ACR_TS_FREE: trig_hit = state_reg == ST_DONE;
			`ACR_TS_CMP1: trig_hit = rise[0];
			`ACR_TS_EXT0: trig_hit = rise[1];
			`ACR_TS_T1OVF: trig_hit = rise[2];
			`ACR_TS_T1CAP: trig_hit = rise[3];
			`ACR_TS_SYNC_R: trig_hit = rise[4] && !busy && !ss_block_reg;
			`ACR_TS_SYNC_2: trig_hit = rise[5] && !busy && !ss_block_reg;
			`ACR_TS_CMP2: trig_hit = rise[6];
			`ACR_TS_CMP3: trig_hit = rise[7];
			default: trig_hit = 1'b0;
		endcase
	end
	wire is_sync = ts == `ACR_TS_SYNC_R || ts == `ACR_TS_SYNC_2;
	wire auto_go = ctl_a_reg[`ACR_ATE] && trig_hit;
	wire sleep_go = SLEEP_ENTRY && !sleep_d_reg && !ctl_b_reg[`ACR_NCDIS];
	wire sw_go = wr_a && REG_WDATA[`ACR_START] && REG_WDATA[`ACR_EN];
	// start written with enable must not wait for the enable bit to land
	wire go = (en || sw_go) && !busy
		&& (auto_go || sleep_go || sw_go || ctl_a_reg[`ACR_START]);
	wire finish = busy && tick && cnt_reg == 5'd0;
	wire can_load = !lock_reg;

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_reg <= ST_IDLE;
			cnt_reg <= 5'd0;
			need_init_reg <= 1'b1;
			SAMPLE <= 1'b0;
			INIT_CYCLE <= 1'b0;
		end else begin
			SAMPLE <= 1'b0;
			if (!en && !busy) begin
				need_init_reg <= 1'b1;
			end
			case (state_reg)
				ST_IDLE, ST_DONE: begin
					state_reg <= ST_IDLE;
					if (go) begin
						state_reg <= ST_CONV;
						SAMPLE <= 1'b1;
						INIT_CYCLE <= need_init_reg;
						need_init_reg <= 1'b0;
						cnt_reg <= need_init_reg ? `ACR_INIT_CYCLES - 5'd1
							: `ACR_CONV_CYCLES - 5'd1;
					end
				end
				ST_CONV: begin
					if (tick) begin
						if (cnt_reg == 5'd0) begin
							state_reg <= ST_DONE;
							INIT_CYCLE <= 1'b0;
						end else begin
							cnt_reg <= cnt_reg - 5'd1;
						end
					end
				end
				default: state_reg <= ST_IDLE;
			endcase
		end
	end

	acr_prescaler u_prescaler (
		.clk(CORE_CLK),
		.resetn(RESETN),
		.run(busy),
		.sel(ctl_a_reg[`ACR_PS_HI:`ACR_PS_LO]),
		.tick(tick)
	);
	assign CONV_CLK_EN = tick;

	// register writes and flags
	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			in_sel_reg <= `ACR_RST_INPUT_SELECT;
			ctl_a_reg <= `ACR_RST_CONTROL_A;
			ctl_b_reg <= `ACR_RST_CONTROL_B;
			pend_mux_reg <= 1'b0;
			pend_val_reg <= 8'h00;
			result_reg <= 10'h000;
			lock_reg <= 1'b0;
			ss_block_reg <= 1'b0;
			REF_SEL <= `ACR_REF_EXT;
			INPUT_SEL <= 4'h0;
		end else begin
			if (wr_in) begin
				// alignment applies now; selection waits for the conversion
				in_sel_reg <= REG_WDATA & `ACR_MASK_INPUT_SELECT;
				if (busy) begin
					pend_mux_reg <= 1'b1;
					pend_val_reg <= REG_WDATA;
				end else begin
					// a newer idle write supersedes a held one
					pend_mux_reg <= 1'b0;
					REF_SEL <= REG_WDATA[`ACR_REFSEL_HI:`ACR_REFSEL_LO];
					INPUT_SEL <= REG_WDATA[`ACR_MUX_HI:`ACR_MUX_LO];
				end
			end else if (pend_mux_reg && !busy) begin
				pend_mux_reg <= 1'b0;
				REF_SEL <= pend_val_reg[`ACR_REFSEL_HI:`ACR_REFSEL_LO];
				INPUT_SEL <= pend_val_reg[`ACR_MUX_HI:`ACR_MUX_LO];
			end
			if (wr_a) begin
				ctl_a_reg[`ACR_EN] <= REG_WDATA[`ACR_EN];
				ctl_a_reg[`ACR_ATE] <= REG_WDATA[`ACR_ATE];
				ctl_a_reg[`ACR_IRQEN] <= REG_WDATA[`ACR_IRQEN];
				ctl_a_reg[`ACR_PS_HI:`ACR_PS_LO] <= REG_WDATA[`ACR_PS_HI:`ACR_PS_LO];
			end
			// start bit: stays high through the conversion unless written one with enable clear, zero write ignored
			if (finish) begin
				ctl_a_reg[`ACR_START] <= 1'b0;
			end else if (go) begin
				ctl_a_reg[`ACR_START] <= 1'b1;
			end else if (wr_a && REG_WDATA[`ACR_START] && !REG_WDATA[`ACR_EN]) begin
				ctl_a_reg[`ACR_START] <= 1'b0;
			end
			// set wins over clear
			if (finish) begin
				ctl_a_reg[`ACR_DONE] <= 1'b1;
			end else if (IRQ_ACK || (wr_a && REG_WDATA[`ACR_DONE])) begin
				ctl_a_reg[`ACR_DONE] <= 1'b0;
			end
			if (wr_b) begin
				ctl_b_reg <= REG_WDATA & `ACR_MASK_CONTROL_B;
			end
			// results lost while locked; the core result is not buffered
			if (finish && can_load) begin
				result_reg <= CORE_RESULT;
			end
			if (rd_hi) begin
				lock_reg <= 1'b0;
			end else if (rd_lo) begin
				lock_reg <= 1'b1;
			end
			// a fresh start beats a high read of the older result
			if (!ctl_b_reg[`ACR_SSEN]) begin
				ss_block_reg <= 1'b0;
			end else if (go && auto_go && is_sync) begin
				ss_block_reg <= 1'b1;
			end else if (rd_hi) begin
				ss_block_reg <= 1'b0;
			end
		end
	end

	assign IRQ_REQ = ctl_a_reg[`ACR_DONE] && ctl_a_reg[`ACR_IRQEN];
	assign CORE_ENABLE = en || busy;
	assign HIGH_SPEED = ctl_b_reg[`ACR_HSM];
	assign INT_REF_ON = REF_SEL[1] && CORE_ENABLE;

	wire left = in_sel_reg[`ACR_LEFT_ADJ];
	wire [7:0] res_lo = left ? {result_reg[1:0], 6'h00} : result_reg[7:0];
	wire [7:0] res_hi = left ? result_reg[9:2] : {6'h00, result_reg[9:8]};

	always @(posedge CORE_CLK or negedge RESETN) begin
		if (!RESETN) begin
			REG_RDATA <= 8'h00;
		end else if (REG_RD) begin
			case (REG_ADDR)
				`ACR_OFF_INPUT_SELECT: REG_RDATA <= in_sel_reg;
				`ACR_OFF_CONTROL_A: REG_RDATA <= ctl_a_reg;
				`ACR_OFF_CONTROL_B: REG_RDATA <= ctl_b_reg;
				`ACR_OFF_RESULT_LOW: REG_RDATA <= res_lo;
				`ACR_OFF_RESULT_HIGH: REG_RDATA <= res_hi;
				`ACR_OFF_CORE_STATUS: REG_RDATA <= {3'h0, lock_reg, ss_block_reg,
					pend_mux_reg, need_init_reg, busy};
				default: REG_RDATA <= 8'h00;
			endcase
		end else begin
			REG_RDATA <= 8'h00;
		end
	end
endmodule // acr_control

// >>> acr_props.sv
`timescale 1ns/1ps
module acr_props (
	// clock and reset
	input wire CORE_CLK,
	input wire RESETN,
	// watched ports
	input wire REG_WR,
	input wire REG_RD,
	input wire [7:0] REG_RDATA,
	input wire [1:0] REF_SEL,
	input wire [3:0] INPUT_SEL,
	input wire INT_REF_ON,
	input wire HIGH_SPEED,
	input wire CORE_ENABLE,
	input wire SAMPLE,
	input wire CONV_CLK_EN
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESETN);
	rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 8'h00)
		else $error("read data not idle");
	int_ref_a: assert property (INT_REF_ON == (REF_SEL[1] & CORE_ENABLE))
		else $error("reference power wrong");
	sample_pulse_a: assert property (SAMPLE |=> !SAMPLE)
		else $error("sample pulse too long");
	sample_en_a: assert property (SAMPLE |-> CORE_ENABLE)
		else $error("sample while disabled");
	enable_hold_a: assert property (SAMPLE |=> CORE_ENABLE [*8])
		else $error("core dropped mid conversion");
	ref_hold_a: assert property (SAMPLE |=> $stable(REF_SEL) [*8])
		else $error("reference moved mid conversion");
	mux_hold_a: assert property (SAMPLE |=> $stable(INPUT_SEL) [*8])
		else $error("input moved mid conversion");
	tick_busy_a: assert property (CONV_CLK_EN |-> CORE_ENABLE)
		else $error("tick while idle");
	tick_gap_a: assert property (CONV_CLK_EN |=> !CONV_CLK_EN)
		else $error("ticks too close");
	hs_write_a: assert property (!$past(REG_WR) |-> $stable(HIGH_SPEED))
		else $error("high speed moved without write");
endmodule // acr_props
bind acr_control acr_props u_props (.CORE_CLK, .RESETN, .REG_WR, .REG_RD, .REG_RDATA,
	.REF_SEL, .INPUT_SEL, .INT_REF_ON, .HIGH_SPEED, .CORE_ENABLE, .SAMPLE, .CONV_CLK_EN);

// >>> acr_core_model.sv
`timescale 1ns/1ps
module acr_core_model (
	// clock and reset
	input wire clk,
	input wire resetn,
	// core side
	input wire sample,
	input wire [3:0] input_sel,
	output logic [9:0] result
);
	// code tied to the channel so the bench can predict it
	always @(posedge clk or negedge resetn) begin
		if (!resetn)
			result <= 10'h000;
		else if (sample)
			result <= {input_sel, 6'h15};
	end
endmodule // acr_core_model

// >>> testbench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin err_total++; \
	$display("mismatch t=%0t got %h exp %h", $time, a, e); end end
module testbench;
	logic clk, rstn, wr, rd, ack, slp, smp, tick, irq, iref, hs, cen, initc;
	logic [2:0] addr;
	logic [7:0] wd, rdata, trig;
	logic [9:0] res;
	logic [1:0] refs;
	logic [3:0] insel;
	int err_total, num_checks, cyc, scnt, i, n;
	initial begin
		clk = 0;
		forever #5 clk = ~clk;
	end
	acr_control DUT (.CORE_CLK(clk), .RESETN(rstn), .REG_ADDR(addr), .REG_WDATA(wd),
		.REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata), .IRQ_ACK(ack), .IRQ_REQ(irq),
		.SLEEP_ENTRY(slp), .CMP1_FLAG(trig[0]), .EXT0_FLAG(trig[1]), .T1_OVF_FLAG(trig[2]),
		.T1_CAP_FLAG(trig[3]), .STAGE_R_SYNC_EVENT(trig[4]), .STAGE_2_SYNC_EVENT(trig[5]),
		.CMP2_FLAG(trig[6]), .CMP3_FLAG(trig[7]), .CORE_RESULT(res), .REF_SEL(refs),
		.INPUT_SEL(insel), .INT_REF_ON(iref), .HIGH_SPEED(hs), .CORE_ENABLE(cen),
		.SAMPLE(smp), .CONV_CLK_EN(tick), .INIT_CYCLE(initc));
	acr_core_model u_core (.clk(clk), .resetn(rstn), .sample(smp), .input_sel(insel),
		.result(res));
	always @(posedge clk) begin
		cyc++;
		if (smp === 1'b1) scnt++;
		if (cyc == 20000) begin
			err_total++;
			report_and_stop;
		end
	end
	task wr8(input logic [2:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wd <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task rd8(input logic [2:0] a, input logic [7:0] e);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 `CHK(rdata, e)
	endtask
	task idle(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask
	// bounded so a dead converter cannot hang the run
	task wirq;
		for (n = 0; n < 4000 && irq !== 1'b1; n++) @(posedge clk);
		#1 `CHK(irq, 1'b1)
	endtask
	task trg(input logic [7:0] b);
		trig <= b;
		idle(3);
		trig <= 8'h00;
		idle(3);
	endtask
	task report_and_stop;
		$display("checks %0d mismatches %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		{rstn, addr, wd, wr, rd, ack, slp, trig} = '0;
		repeat (10) @(posedge clk);
		rstn <= 1'b1;
		for (i = 0; i < 3; i++) rd8(i[2:0], 8'h00);
		rd8(3'h6, 8'h00);
		rd8(3'h5, 8'h02);
		wr8(3'h0, 8'hff);
		rd8(3'h0, 8'hef);
		wr8(3'h2, 8'hff);
		rd8(3'h2, 8'hdf);
		`CHK(hs, 1'b1)
		`CHK(refs, 2'h3)
		`CHK(iref, 1'b0)
		wr8(3'h2, 8'h00);
		wr8(3'h1, 8'h80);
		idle(2);
		`CHK(iref, 1'b1)
		$display("registers done");
		wr8(3'h0, 8'h4c);
		wr8(3'h1, 8'hc8);
		idle(3);
		`CHK(initc, 1'b1)
		wirq();
		rd8(3'h1, 8'h98);
		rd8(3'h3, 8'h15);
		rd8(3'h4, 8'h03);
		wr8(3'h0, 8'h6c);
		rd8(3'h3, 8'h40);
		rd8(3'h4, 8'hc5);
		wr8(3'h1, 8'h98);
		rd8(3'h1, 8'h88);
		wr8(3'h1, 8'hc8);
		wr8(3'h0, 8'h43);
		#1 `CHK(insel, 4'hc)
		wirq();
		idle(2);
		`CHK(insel, 4'h3)
		rd8(3'h3, 8'h15);
		rd8(3'h4, 8'h03);
		ack <= 1'b1;
		@(posedge clk);
		ack <= 1'b0;
		idle(1);
		`CHK(irq, 1'b0)
		wr8(3'h1, 8'hc0);
		idle(200);
		`CHK(irq, 1'b0)
		rd8(3'h1, 8'h90);
		wr8(3'h1, 8'h98);
		$display("conversion done");
		for (i = 0; i < 8; i++) begin
			wr8(3'h1, 8'hc8 | i[7:0]);
			#1;
			for (n = 0; n < 300 && tick !== 1'b1; n++) @(posedge clk) #1;
			n = 0;
			do begin
				@(posedge clk) #1;
				n++;
			end while (tick !== 1'b1 && n < 300);
			`CHK(n, (i < 2) ? 2 : (1 << i))
			wirq();
			wr8(3'h1, 8'h98);
		end
		for (i = 1; i < 9; i++) begin
			wr8(3'h2, i[7:0]);
			wr8(3'h1, 8'hb8);
			trg(8'h01 << (i - 1));
			wirq();
			wr8(3'h1, 8'h98);
		end
		wr8(3'h2, 8'h09);
		wr8(3'h1, 8'hb8);
		i = scnt;
		trg(8'hff);
		idle(40);
		`CHK(scnt, i)
		wr8(3'h2, 8'h15);
		trg(8'h10);
		wirq();
		wr8(3'h1, 8'hb8);
		i = scnt;
		trg(8'h10);
		idle(60);
		`CHK(scnt, i)
		rd8(3'h4, 8'h00);
		trg(8'h10);
		wirq();
		$display("triggers done");
		wr8(3'h2, 8'h40);
		wr8(3'h1, 8'h98);
		i = scnt;
		slp <= 1'b1;
		idle(60);
		`CHK(scnt, i)
		slp <= 1'b0;
		wr8(3'h2, 8'h00);
		slp <= 1'b1;
		idle(60);
		`CHK(scnt, i + 1)
		slp <= 1'b0;
		wr8(3'h1, 8'he8);
		i = scnt;
		idle(200);
		`CHK(scnt >= i + 3, 1'b1)
		wr8(3'h1, 8'h00);
		idle(60);
		`CHK(cen, 1'b0)
		wr8(3'h1, 8'hd8);
		idle(2);
		`CHK(initc, 1'b1)
		wr8(3'h1, 8'h08);
		#1 `CHK(cen, 1'b1)
		wirq();
		rd8(3'h1, 8'h18);
		idle(2);
		`CHK(cen, 1'b0)
		$display("modes done");
		report_and_stop;
	end
endmodule // testbench
